// >>> bench/csg_sys_model.sv
// partner model: integration logic that may stop the raw clock in sleep
`timescale 1ns/1ps

module csg_sys_model
(
   input wire logic clk_src,
   input wire logic core_sleep_q,
   input wire logic wake_in,
   output logic clk_sys
);
   logic run_q; // external clock enable, latched

   // latch only while the source is low, so no cut pulses
   always_latch
   begin
      if (!clk_src)
         run_q <= !core_sleep_q || wake_in;
   end

   assign clk_sys = clk_src & run_q;
endmodule : csg_sys_model

// >>> bench/tb_top.sv
// self-checking bench for the core sleep clock gate
`timescale 1ns/1ps

module tb_top
   import csg_pkg::*;
;
   logic clk_src = 1'h0; // free source clock
   logic sys_rst = 1'h1;
   logic core_rst_n = 1'h1;
   logic fetch = 1'h0;
   logic ev = 1'h0;
   logic wake;
   logic clk_sys, clk_gated, core_sleep_q, gate_en_q;
   csg_insn_t insn = '0;
   csg_dbg_t dbg = '0;
   logic [31:0] irq_p = '0;
   logic [31:0] irq_e = '0;
   int errors = 0;
   int check_count = 0;
   int pulses = 0; // gated clock edges seen

   always #50 clk_src = ~clk_src;
   always @(posedge clk_gated) pulses++;
   // any wake cause lets the partner run the raw clock again
   assign wake = |(irq_p & irq_e) | dbg.req_in | dbg.req_pending | dbg.mode | ev;

   csg_sys_model i_sys (.clk_src(clk_src), .core_sleep_q(core_sleep_q),
      .wake_in(wake), .clk_sys(clk_sys));
   csg_sleep_unit i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .reset_active_low_in(core_rst_n), .fetch_enable_in(fetch), .insn_in(insn),
      .irq_pending_in(irq_p), .irq_enable_in(irq_e), .dbg_in(dbg),
      .event_wakeup_in(ev), .clk_gated(clk_gated), .core_sleep_q(core_sleep_q),
      .gate_en_q(gate_en_q));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic got, input logic exp, input string m);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_src);
   endtask : cyc
   // sleep flag and gate enable together
   task automatic st(input logic s, input logic g);
      chk(core_sleep_q, s, "sleep flag");
      chk(gate_en_q, g, "gate enable");
   endtask : st
   // exp high: gated clock must not pulse over n cycles
   task automatic quiet(input int n, input logic exp);
      int p0;
      p0 = pulses;
      cyc(n);
      chk(logic'(pulses == p0), exp, "gated clock activity");
   endtask : quiet
   // one-cycle retiring pulse, then one more edge for the answer
   task automatic issue(input logic [31:0] w);
      insn = '{valid: 1'h1, insn: w};
      cyc(1);
      insn = '0;
      cyc(1);
   endtask : issue

   ////////////////////////////////////////////////////////////////////////////////
   // r high: system reset, else core reset; fetch permit low through reset, then raised for two cycles
   task automatic t_start(input logic r);
      if (r)
         sys_rst = 1'h1;
      else
         core_rst_n = 1'h0;
      cyc(3);
      st(1'h0, 1'h0);
      quiet(7, 1'h1);
      sys_rst = 1'h0;
      core_rst_n = 1'h1;
      quiet(5, 1'h1);
      st(1'h0, 1'h0);
      fetch = 1'h1;
      cyc(2);
      st(1'h0, 1'h1);
      fetch = 1'h0;
      quiet(3, 1'h0);
      st(1'h0, 1'h1);
   endtask : t_start
   // wfi ignores the event input, here wakes on an enabled interrupt
   task automatic t_wfi();
      issue(CSG_WFI_INSN);
      st(1'h1, 1'h0);
      quiet(4, 1'h1);
      ev = 1'h1;
      cyc(2);
      st(1'h1, 1'h0);
      ev = 1'h0;
      irq_p[5] = 1'h1;
      irq_e[5] = 1'h1;
      cyc(2);
      st(1'h0, 1'h1);
      quiet(3, 1'h0);
      irq_p = '0;
      irq_e = '0;
   endtask : t_wfi
   // wfe wakes on the event input; a near encoding is not wfe
   task automatic t_wfe();
      issue(CSG_WFE_INSN);
      st(1'h1, 1'h0);
      ev = 1'h1;
      cyc(2);
      st(1'h0, 1'h1);
      ev = 1'h0;
      issue(CSG_WFE_INSN ^ 32'h0100_0000);
      st(1'h0, 1'h1);
   endtask : t_wfe
   // each debug condition turns wfi, then a coinciding interrupt turns wfe, into a nop
   task automatic t_nop();
      for (int i = 0; i < 5; i++)
      begin
         dbg = csg_dbg_t'(5'h01 << i);
         issue(CSG_WFI_INSN);
         st(1'h0, 1'h1);
         dbg = '0;
      end
      irq_p[0] = 1'h1;
      irq_e[0] = 1'h1;
      issue(CSG_WFE_INSN);
      st(1'h0, 1'h1);
      irq_p = '0;
      irq_e = '0;
      // event already high when wfe retires: no sleep either
      ev = 1'h1;
      issue(CSG_WFE_INSN);
      st(1'h0, 1'h1);
      ev = 1'h0;
   endtask : t_nop
   // debug mode, pending request and request input each end sleep
   task automatic t_dbgwake();
      for (int i = 2; i < 5; i++)
      begin
         issue(CSG_WFI_INSN);
         st(1'h1, 1'h0);
         dbg = csg_dbg_t'(5'h01 << i);
         cyc(2);
         st(1'h0, 1'h1);
         dbg = '0;
      end
   endtask : t_dbgwake

   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : summarize

   // main sequence, ends with a second reset mid-run
   initial
   begin
      t_start(1'h1);
      t_wfi();
      t_wfe();
      t_nop();
      t_dbgwake();
      t_start(1'h0);
      summarize();
   end
   // watchdog: some twenty times the expected run of about 100 cycles
   initial
   begin
      #200000;
      errors++;
      summarize();
   end
endmodule : tb_top

// >>> rtl/csg_pkg.sv
// package of constants and carrier types for the core sleep clock gate
package csg_pkg;

   // full 32-bit encoding of the custom wait-for-event instruction
   localparam logic [31:0] CSG_WFE_INSN = 32'h8C00_0073;
   // full 32-bit encoding of the standard wait-for-interrupt instruction
   localparam logic [31:0] CSG_WFI_INSN = 32'h1050_0073;
   // width of the local interrupt vector
   localparam int CSG_IRQ_W = 32;
   // reset level of the sleep indication
   localparam logic CSG_SLEEP_RST = 1'h0;

   // sleep controller states
   typedef enum logic [1:0]
   {
      CSG_ST_START = 2'b00, // gated, waiting for the first fetch permit
      CSG_ST_RUN   = 2'b01, // clock running
      CSG_ST_SLEEP = 2'b10  // gated by a wait instruction
   } csg_state_t;

   // debug conditions that suppress sleep; req_in, req_pending and mode also end it
   typedef struct packed
   {
      logic req_in;      // debug request input level
      logic req_pending; // debug request already pending in the core
      logic mode;        // core is in debug mode
      logic step;        // single stepping
      logic trig;        // trigger match
   } csg_dbg_t;

   // retiring instruction carried from the core pipeline
   typedef struct packed
   {
      logic        valid; // instruction retires this cycle
      logic [31:0] insn;  // its full encoding
   } csg_insn_t;

endpackage : csg_pkg

// >>> rtl/csg_sleep_unit.sv
// sleep unit: owns the raw core clock and produces the gated core clock
//
// How it works
// - one clock gate feeds every other module
// - only this unit ever uses the raw clock
// - gate held closed while reset asserted
// - gated after reset until fetch permit seen
// - sleep output stays low during startup gating
// - fetch permit ignored until next reset
// - wfi sleeps for local interrupts, ignores mstatus
// - wfi is nop under debug conditions
// - sleep entry raises sleep output, closes gate
// - wake on local interrupt, debug pending, debug mode
// - wake lowers sleep output, reopens gate, resumes
// - wake present at instruction means no sleep
// - wfe is wfi plus event wake input
// - wfe decoded as full 32-bit system encoding
`timescale 1ns/1ps

module csg_sleep_unit
   import csg_pkg::*;
#(
   parameter int IRQ_W = CSG_IRQ_W
)
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic reset_active_low_in,
   input wire logic fetch_enable_in,
   input wire csg_insn_t insn_in,
   input wire logic [IRQ_W-1:0] irq_pending_in,
   input wire logic [IRQ_W-1:0] irq_enable_in,
   input wire csg_dbg_t dbg_in,
   input wire logic event_wakeup_in,
   output logic clk_gated,
   output logic core_sleep_q,
   output logic gate_en_q
);

   ////////////////////////////////////////////////////////////////////////
   // decode and wake conditions

   // match a retiring instruction against one encoding
   function automatic logic csg_is_insn(input csg_insn_t i, input logic [31:0] enc);
      csg_is_insn = i.valid && (i.insn == enc);
   endfunction : csg_is_insn

   logic core_rst; // either reset source
   logic is_wfi; // wfi retiring
   logic is_wfe; // wfe retiring
   logic irq_wake; // locally enabled interrupt pending
   logic dbg_nop; // debug conditions that turn wfi into nop
   logic dbg_wake; // debug conditions that end sleep
   logic wfe_mode_q; // current sleep was entered by wfe
   logic wake_now; // any wake source for the pending or current wait
   csg_state_t state_q;

   assign core_rst = sys_rst || !reset_active_low_in;
   assign is_wfi = csg_is_insn(insn_in, CSG_WFI_INSN);
   assign is_wfe = csg_is_insn(insn_in, CSG_WFE_INSN);
   // global enables are deliberately not looked at
   assign irq_wake = |(irq_pending_in & irq_enable_in);
   assign dbg_nop = dbg_in.req_in || dbg_in.req_pending || dbg_in.mode
                    || dbg_in.step || dbg_in.trig;
   assign dbg_wake = dbg_in.req_in || dbg_in.req_pending || dbg_in.mode;
   // event input counts only for wfe, at entry and while asleep
   assign wake_now = irq_wake || dbg_wake
                     || (event_wakeup_in && ((state_q == CSG_ST_SLEEP) ? wfe_mode_q
                                                                       : is_wfe));

   ////////////////////////////////////////////////////////////////////////
   // sleep state machine, on the raw clock so wakes are seen while gated

   // reset sources are async; reset forces the startup state
   always_ff @(posedge clk_sys or posedge core_rst)
   begin
      if (core_rst)
      begin
         state_q <= CSG_ST_START;
      end
      else
      begin
         case (state_q)
            CSG_ST_START:
            begin
               // first permit ends startup; later levels are never read
               if (fetch_enable_in)
               begin
                  state_q <= CSG_ST_RUN;
               end
            end
            CSG_ST_RUN:
            begin
               // coincident wake or debug means nop, no sleep
               if ((is_wfi || is_wfe) && !dbg_nop && !wake_now)
               begin
                  state_q <= CSG_ST_SLEEP;
               end
            end
            CSG_ST_SLEEP:
            begin
               if (wake_now)
               begin
                  state_q <= CSG_ST_RUN;
               end
            end
            default:
            begin
               state_q <= CSG_ST_START;
            end
         endcase
      end
   end

   // remember which instruction put the core to sleep
   always_ff @(posedge clk_sys or posedge core_rst)
   begin
      if (core_rst)
      begin
         wfe_mode_q <= 1'h0;
      end
      else if (state_q == CSG_ST_RUN)
      begin
         wfe_mode_q <= is_wfe;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs, each straight from a flip-flop

   // sleep flag only for wait-instruction sleep, never for startup gating
   always_ff @(posedge clk_sys or posedge core_rst)
   begin
      if (core_rst)
      begin
         core_sleep_q <= CSG_SLEEP_RST;
      end
      else
      begin
         case (state_q)
            CSG_ST_RUN:
            begin
               core_sleep_q <= (is_wfi || is_wfe) && !dbg_nop && !wake_now;
            end
            CSG_ST_SLEEP:
            begin
               core_sleep_q <= !wake_now;
            end
            default:
            begin
               // startup gating never shows as sleep
               core_sleep_q <= CSG_SLEEP_RST;
            end
         endcase
      end
   end

   // gate enable tracks the next state so the clock stops with the flag
   always_ff @(posedge clk_sys or posedge core_rst)
   begin
      if (core_rst)
      begin
         gate_en_q <= 1'h0;
      end
      else
      begin
         case (state_q)
            CSG_ST_START: gate_en_q <= fetch_enable_in;
            CSG_ST_RUN: gate_en_q <= !((is_wfi || is_wfe) && !dbg_nop && !wake_now);
            CSG_ST_SLEEP: gate_en_q <= wake_now;
            default: gate_en_q <= 1'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // the single clock gate; latch transparent while the clock is low

   logic gate_latch; // enable held stable through the high phase
   always_latch
   begin
      if (!clk_sys)
      begin
         gate_latch = gate_en_q;
      end
   end
   // every other core module is clocked from here only
   assign clk_gated = clk_sys & gate_latch;

   ////////////////////////////////////////////////////////////////////////
   // checks

   sequence s_wait_taken;
      state_q == CSG_ST_RUN && (is_wfi || is_wfe) && !dbg_nop && !wake_now;
   endsequence

   property p_start_no_sleep;
      @(posedge clk_sys) disable iff (core_rst)
      state_q == CSG_ST_START |-> !core_sleep_q;
   endproperty
   a_start_no_sleep: assert property (p_start_no_sleep)
      else $error("sleep flag high during startup");

   property p_start_gated;
      @(posedge clk_sys) disable iff (core_rst)
      (state_q == CSG_ST_START && !fetch_enable_in) |=> !gate_en_q;
   endproperty
   a_start_gated: assert property (p_start_gated)
      else $error("gate opened before fetch permit");

   property p_permit_ignored;
      @(posedge clk_sys) disable iff (core_rst)
      (state_q != CSG_ST_START) |=> (state_q != CSG_ST_START);
   endproperty
   a_permit_ignored: assert property (p_permit_ignored)
      else $error("returned to startup without reset");

   property p_enter;
      @(posedge clk_sys) disable iff (core_rst)
      s_wait_taken |=> (core_sleep_q && !gate_en_q && state_q == CSG_ST_SLEEP);
   endproperty
   a_enter: assert property (p_enter)
      else $error("sleep entry did not raise flag and close gate");

   property p_nop_debug;
      @(posedge clk_sys) disable iff (core_rst)
      (state_q == CSG_ST_RUN && dbg_nop) |=> !core_sleep_q;
   endproperty
   a_nop_debug: assert property (p_nop_debug)
      else $error("slept under debug condition");

   property p_coincident;
      @(posedge clk_sys) disable iff (core_rst)
      (state_q == CSG_ST_RUN && irq_wake) |=> (gate_en_q && !core_sleep_q);
   endproperty
   a_coincident: assert property (p_coincident)
      else $error("slept with wake already present");

   property p_wake;
      @(posedge clk_sys) disable iff (core_rst)
      (state_q == CSG_ST_SLEEP && (irq_wake || dbg_wake)) |=> (!core_sleep_q && gate_en_q);
   endproperty
   a_wake: assert property (p_wake)
      else $error("no wake on interrupt or debug");

   property p_wfe_event;
      @(posedge clk_sys) disable iff (core_rst)
      (state_q == CSG_ST_SLEEP && wfe_mode_q && event_wakeup_in)
         |=> (state_q == CSG_ST_RUN) ##0 gate_en_q;
   endproperty
   a_wfe_event: assert property (p_wfe_event)
      else $error("wfe sleep ignored event wake");

   property p_flag_gate;
      @(posedge clk_sys) disable iff (core_rst)
      core_sleep_q |-> !gate_en_q;
   endproperty
   a_flag_gate: assert property (p_flag_gate)
      else $error("sleep flag high with gate open");

endmodule : csg_sleep_unit
